// >>> logic/dps_pkg.sv
// constants used by the channel scheduler; its per-channel state store does not import them
// assumes one clock domain; all counts are in scheduler clock cycles
package dps_pkg;

  // per-phase cycle counts of one triggered transaction
  localparam int unsigned SYNC_CYCLES = 3;        // trigger sync and priority decode
  localparam int unsigned START_CYCLES = 3;       // start engine, load channel config
  localparam int unsigned DESC_SINGLE_CYCLES = 4; // descriptor words, single transfer
  localparam int unsigned DESC_1D_CYCLES = 5;     // descriptor words, 1d transfer
  localparam int unsigned DESC_2D_CYCLES = 6;     // descriptor words, 2d transfer
  localparam int unsigned NEXT_PTR_CYCLES = 1;    // next-descriptor pointer
  localparam int unsigned DATA_CYCLES = 3;        // one element, source to destination

  // step counter width and transfer mode encodings
  localparam int unsigned STEP_W = 3;
  localparam int unsigned MODE_W = 2;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_1D = 2'h1;
  localparam logic [1:0] MODE_2D = 2'h2;

  // shared engine phases
  typedef enum logic [2:0] {
    DPS_IDLE,
    DPS_SYNC,
    DPS_START,
    DPS_DESC,
    DPS_NEXTP,
    DPS_DATA
  } dps_phase_e;

endpackage : dps_pkg

// >>> logic/dps_chan_mem.sv
// per-channel state store: one entry of {descriptor loaded, elements left} per channel
// assumes a synchronous active-high reset; read data come out of a register
`timescale 1ns/1ps
module dps_chan_mem #(
  parameter int unsigned DEPTH = 4,
  parameter int unsigned WIDTH = 17,
  parameter int unsigned AW = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read port, one cycle latency
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  ////////////////////////////////////////////////////////////////////////////////
  // one dedicated state word per channel, cleared by reset so no entry is stale
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (rst) begin
        mem[i] <= '0;
      end else if (wr_en && (wr_addr == AW'(i))) begin
        mem[i] <= wr_data;
      end
    end
  end

  // registered read
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : dps_chan_mem

// >>> logic/dps_sched.sv
// multi-channel dma scheduler: trigger pending, priority pick, preemption and phase timing
// assumes the system bus arbiter outside answers BUS_REQ with BUS_GNT
//
// What this block does
// - the memory_dma_controller variant keeps each channel's state in its own storage entry.
// - the memory_dma_controller variant spends only sync and priority decode on a trigger that resumes retained state.
// - a channel waiting for its next trigger releases the engine to other pending channels.
// - a preempted channel stays pending for as long as any higher-priority channel runs.
// - the peripheral_dma variant refetches the descriptor every time a channel resumes.
// - the memory_dma_controller variant resumes from retained state with no descriptor fetch.
// - only channels marked preemptable may be preempted; others keep the engine until done or until they wait for a trigger.
// - starting the engine and loading channel config takes three cycles after sync.
// - descriptor load takes 4, 5 or 6 granted cycles by mode, then one for the next pointer.
// - each data element takes three granted cycles from source to destination.
`timescale 1ns/1ps
module dps_sched #(
  parameter int unsigned NCH = 4,            // channels in this block
  parameter int unsigned MASTER_PRIORITY_FIELD_W = 2,         // priority width, lower value wins
  parameter int unsigned CNT_W = 16,         // element count width
  parameter bit MEMORY_VARIANT = 1'b0        // 1: memory_dma_controller, 0: peripheral_dma
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // per-channel setup
  input wire logic [NCH-1:0] CH_ENABLE,
  input wire logic [NCH-1:0] CH_PREEMPTABLE,
  input wire logic [NCH-1:0] CH_PER_TRIGGER,
  input wire logic [NCH*MASTER_PRIORITY_FIELD_W-1:0] CH_PRIORITY,
  input wire logic [NCH*dps_pkg::MODE_W-1:0] CH_MODE,
  input wire logic [NCH*CNT_W-1:0] CH_LENGTH,
  // triggers, one-cycle pulses
  input wire logic [NCH-1:0] TRIGGER,
  // system bus handshake
  input wire logic BUS_GNT,
  output logic BUS_REQ,
  output logic BUS_DESC_FETCH,
  // status
  output logic ACTIVE,
  output logic [$clog2(NCH)-1:0] ACTIVE_CH,
  output logic [NCH-1:0] CH_PENDING,
  output logic ELEM_DONE,
  output logic [NCH-1:0] CH_DONE
);

  localparam int unsigned CH_W = $clog2(NCH);
  localparam int unsigned MW = CNT_W + 1;
  localparam logic [dps_pkg::STEP_W-1:0] SYNC_LAST = 3'(dps_pkg::SYNC_CYCLES - 1);
  localparam logic [dps_pkg::STEP_W-1:0] START_LAST = 3'(dps_pkg::START_CYCLES - 1);
  localparam logic [dps_pkg::STEP_W-1:0] NEXTP_LAST = 3'(dps_pkg::NEXT_PTR_CYCLES - 1);
  localparam logic [dps_pkg::STEP_W-1:0] DATA_LAST = 3'(dps_pkg::DATA_CYCLES - 1);

  // parameter sanity
  if (NCH < 2 || NCH > 32 || MASTER_PRIORITY_FIELD_W < 1 || CNT_W < 2 || CNT_W > 30) begin : g_bad_param
    $error("dps_sched: unsupported NCH, MASTER_PRIORITY_FIELD_W or CNT_W");
  end

  typedef struct packed {
    dps_pkg::dps_phase_e phase;
    logic [dps_pkg::STEP_W-1:0] step;
    logic [CH_W-1:0] act;
    logic [CNT_W-1:0] remain;
    logic loaded;
    logic [NCH-1:0] pend;
    logic active;
    logic bus_req;
    logic fetch;
    logic elem_done;
    logic [NCH-1:0] ch_done;
  } dps_state_s;

  dps_state_s st;
  dps_state_s next_st;

  logic adv;
  logic [CH_W-1:0] best;
  logic hi_pend;
  logic [MASTER_PRIORITY_FIELD_W-1:0] act_master_priority_field;
  logic [dps_pkg::STEP_W-1:0] desc_last;
  logic [CH_W-1:0] rd_addr;
  logic [MW-1:0] rd_data;
  logic wr_en;
  logic [MW-1:0] wr_data;
  logic elem_fire;
  logic preempt_fire;

  ////////////////////////////////////////////////////////////////////////////////
  // priority decode: ties go to the lowest channel index
  always_comb begin
    logic found;
    logic [MASTER_PRIORITY_FIELD_W-1:0] bprio;
    found = 1'b0;
    bprio = '0;
    best = '0;
    hi_pend = 1'b0;
    act_master_priority_field = CH_PRIORITY[st.act*MASTER_PRIORITY_FIELD_W +: MASTER_PRIORITY_FIELD_W];
    for (int i = 0; i < NCH; i++) begin
      if (st.pend[i] && (!found || CH_PRIORITY[i*MASTER_PRIORITY_FIELD_W +: MASTER_PRIORITY_FIELD_W] < bprio)) begin
        found = 1'b1;
        bprio = CH_PRIORITY[i*MASTER_PRIORITY_FIELD_W +: MASTER_PRIORITY_FIELD_W];
        best = CH_W'(i);
      end
      if (st.pend[i] && CH_PRIORITY[i*MASTER_PRIORITY_FIELD_W +: MASTER_PRIORITY_FIELD_W] < act_master_priority_field) begin
        hi_pend = 1'b1;
      end
    end
  end

  // descriptor length of the active channel's mode
  always_comb begin
    case (CH_MODE[st.act*dps_pkg::MODE_W +: dps_pkg::MODE_W])
      dps_pkg::MODE_SINGLE: desc_last = 3'(dps_pkg::DESC_SINGLE_CYCLES - 1);
      dps_pkg::MODE_1D: desc_last = 3'(dps_pkg::DESC_1D_CYCLES - 1);
      default: desc_last = 3'(dps_pkg::DESC_2D_CYCLES - 1);
    endcase
  end

  // bus phases only advance on a granted cycle; the arbiter may stall any of them
  assign adv = st.bus_req & BUS_GNT;
  assign rd_addr = (st.phase == dps_pkg::DPS_IDLE) ? best : st.act;
  assign elem_fire = (st.phase == dps_pkg::DPS_DATA) && adv && (st.step == DATA_LAST);
  assign preempt_fire = elem_fire && (st.remain > CNT_W'(1)) && !CH_PER_TRIGGER[st.act] &&
                        CH_PREEMPTABLE[st.act] && hi_pend;

  // per-channel state store; the shared engine writes progress back on every release
  dps_chan_mem #(.DEPTH(NCH), .WIDTH(MW), .AW(CH_W)) u_mem (
    .clk(CORE_CLK),
    .rst(RESET),
    .wr_en(wr_en),
    .wr_addr(st.act),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // engine sequencing
  always_comb begin
    logic [NCH-1:0] clr;
    logic [NCH-1:0] set;
    logic [CNT_W-1:0] left;
    clr = '0;
    set = TRIGGER & CH_ENABLE;
    left = st.remain - CNT_W'(1);
    next_st = st;
    next_st.elem_done = 1'b0;
    next_st.ch_done = '0;
    wr_en = 1'b0;
    wr_data = '0;
    case (st.phase)
      dps_pkg::DPS_IDLE: begin
        if (|st.pend) begin
          next_st.act = best;
          clr[best] = 1'b1;
          next_st.phase = dps_pkg::DPS_SYNC;
          next_st.step = '0;
          next_st.active = 1'b1;
        end
      end
      dps_pkg::DPS_SYNC: begin
        if (st.step == SYNC_LAST) begin
          // a finished or never-started entry restarts from the programmed length
          if (rd_data[CNT_W] && rd_data[CNT_W-1:0] != '0) begin
            next_st.remain = rd_data[CNT_W-1:0];
            next_st.loaded = 1'b1;
          end else begin
            next_st.remain = CH_LENGTH[st.act*CNT_W +: CNT_W];
            next_st.loaded = 1'b0;
          end
          next_st.step = '0;
          if (MEMORY_VARIANT && next_st.loaded) begin
            next_st.phase = dps_pkg::DPS_DATA;
            next_st.bus_req = 1'b1;
            next_st.fetch = 1'b0;
          end else begin
            next_st.phase = dps_pkg::DPS_START;
          end
        end else begin
          next_st.step = st.step + 3'h1;
        end
      end
      dps_pkg::DPS_START: begin
        if (st.step == START_LAST) begin
          next_st.phase = dps_pkg::DPS_DESC;
          next_st.step = '0;
          next_st.bus_req = 1'b1;
          next_st.fetch = 1'b1;
        end else begin
          next_st.step = st.step + 3'h1;
        end
      end
      dps_pkg::DPS_DESC: begin
        if (adv) begin
          if (st.step == desc_last) begin
            next_st.phase = dps_pkg::DPS_NEXTP;
            next_st.step = '0;
          end else begin
            next_st.step = st.step + 3'h1;
          end
        end
      end
      dps_pkg::DPS_NEXTP: begin
        if (adv) begin
          if (st.step == NEXTP_LAST) begin
            next_st.phase = dps_pkg::DPS_DATA;
            next_st.step = '0;
            next_st.fetch = 1'b0;
            next_st.loaded = 1'b1;
          end else begin
            next_st.step = st.step + 3'h1;
          end
        end
      end
      dps_pkg::DPS_DATA: begin
        if (elem_fire) begin
          next_st.elem_done = 1'b1;
          next_st.step = '0;
          next_st.remain = left;
          if (st.remain <= CNT_W'(1)) begin
            // transfer complete: the entry is marked stale so a new trigger starts over
            next_st.ch_done[st.act] = 1'b1;
            wr_en = 1'b1;
          end else if (CH_PER_TRIGGER[st.act] || preempt_fire) begin
            // waiting for a trigger or preempted: hand the engine back, keep progress
            wr_en = 1'b1;
            wr_data = {1'b1, left};
            set[st.act] = set[st.act] | preempt_fire; // re-marks the preempted channel pending
          end
          // a non-preemptable channel simply keeps moving elements
          if (wr_en) begin
            next_st.phase = dps_pkg::DPS_IDLE;
            next_st.active = 1'b0;
            next_st.bus_req = 1'b0;
          end
        end else if (adv) begin
          next_st.step = st.step + 3'h1;
        end
      end
      default: begin
        next_st.phase = dps_pkg::DPS_IDLE;
        next_st.active = 1'b0;
        next_st.bus_req = 1'b0;
      end
    endcase
    // a trigger landing on the cycle its pending bit is taken is kept
    next_st.pend = (st.pend & ~clr) | set;
  end

  // state register
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs, all straight from the state register
  assign BUS_REQ = st.bus_req;
  assign BUS_DESC_FETCH = st.fetch;
  assign ACTIVE = st.active;
  assign ACTIVE_CH = st.act;
  assign CH_PENDING = st.pend;
  assign ELEM_DONE = st.elem_done;
  assign CH_DONE = st.ch_done;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  logic in_sync;
  logic in_start;
  assign in_sync = (st.phase == dps_pkg::DPS_SYNC);
  assign in_start = (st.phase == dps_pkg::DPS_START);

  chk_sync_three: assert property ($rose(in_sync) |-> in_sync[*3] ##1 !in_sync)
    else $error("sync phase not three cycles");
  chk_start_three: assert property ($rose(in_start) |-> in_start[*3] ##1
    (st.phase == dps_pkg::DPS_DESC && BUS_REQ && BUS_DESC_FETCH))
    else $error("start phase not three cycles then descriptor fetch");
  chk_desc_len: assert property ((st.phase == dps_pkg::DPS_DESC && adv &&
    st.step == desc_last) |=> st.phase == dps_pkg::DPS_NEXTP ##0 BUS_REQ)
    else $error("descriptor load length wrong");
  chk_elem_pulse: assert property ((st.phase == dps_pkg::DPS_DATA && adv &&
    st.step == 3'h2) |=> ELEM_DONE)
    else $error("element not done after three granted cycles");
  chk_pick_best: assert property ((st.phase == dps_pkg::DPS_IDLE && |st.pend) |=>
    (in_sync && ACTIVE && ACTIVE_CH == $past(best)))
    else $error("idle engine did not pick best pending channel");
  chk_resume_direct: assert property ((MEMORY_VARIANT && in_sync &&
    st.step == SYNC_LAST && rd_data[CNT_W] && rd_data[CNT_W-1:0] != '0) |=>
    (st.phase == dps_pkg::DPS_DATA && !BUS_DESC_FETCH))
    else $error("retained channel repeated descriptor fetch");
  chk_refetch: assert property ((!MEMORY_VARIANT && $fell(in_sync)) |-> in_start)
    else $error("peripheral variant skipped descriptor refetch");
  chk_preempt_pend: assert property (preempt_fire |=>
    (st.phase == dps_pkg::DPS_IDLE && st.pend[st.act]))
    else $error("preempted channel not left pending");
  chk_no_preempt: assert property ((elem_fire && !CH_PREEMPTABLE[st.act] &&
    !CH_PER_TRIGGER[st.act] && st.remain > CNT_W'(1)) |=> st.phase == dps_pkg::DPS_DATA)
    else $error("non-preemptable channel lost the engine");
  chk_trig_release: assert property ((elem_fire && CH_PER_TRIGGER[st.act] &&
    st.remain > CNT_W'(1)) |=> (!ACTIVE ##1 (ACTIVE == ($past(CH_PENDING) != '0))))
    else $error("waiting channel did not release the engine");

endmodule : dps_sched

// >>> tb/dps_bus_arb_model.sv
// partner model: system bus fabric that the dma scheduler shares with other masters
// assumes one clock; other masters keep the bus for lat cycles after each new request
`timescale 1ns/1ps
module dps_bus_arb_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // dma request, grant and arbitration delay
  input wire logic bus_req,
  input wire logic [3:0] lat,
  output logic bus_gnt
);
  logic [3:0] wait_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // cycles the current request has waited; restarts on every release of the bus
  always @(posedge clk) begin
    if (rst || !bus_req) begin
      wait_cnt <= 4'h0;
    end else if (wait_cnt < lat) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  // higher master_priority_field masters win until the wait runs out,
  // for descriptor fetches and data alike; no grant while nothing is asked
  assign bus_gnt = bus_req && (wait_cnt >= lat);
endmodule : dps_bus_arb_model

// >>> tb/dps_sched_test.sv
// testbench: both scheduler variants side by side on the same stimulus
// assumes one bus arbiter model per variant; outputs are sampled at rising edges
`timescale 1ns/1ps
module dps_sched_test;
  localparam int LIMIT = 20000;
  logic clk;
  logic rst = 1'b1;
  logic [3:0] en = 4'hf;
  logic [3:0] pre = 4'h0;
  logic [3:0] per = 4'h0;
  logic [3:0] trig = 4'h0;
  logic [7:0] master_priority_field = 8'hd8;
  logic [7:0] mode = 8'h0;
  logic [63:0] len = {4{16'h1}};
  logic [3:0] lat = 4'h0;
  wire [1:0] req, gnt, descf, act, edone;
  wire [1:0][1:0] ach;
  wire [1:0][3:0] pend, cdone;
  int cyc = 0;
  int t0, watch = 0;
  int miscompares = 0;
  int checks = 0;
  int t_done[2], dcnt[2], ecnt[2], fdone[2], viol[2];

  ////////////////////////////////////////////////////////////////////////////////
  // index 0 is peripheral_dma, index 1 is memory_dma_controller
  for (genvar v = 0; v < 2; v++) begin : g_var
    dps_sched #(.MEMORY_VARIANT(v == 1)) dut (
      .CORE_CLK(clk), .RESET(rst), .CH_ENABLE(en), .CH_PREEMPTABLE(pre),
      .CH_PER_TRIGGER(per), .CH_PRIORITY(master_priority_field), .CH_MODE(mode), .CH_LENGTH(len),
      .TRIGGER(trig), .BUS_GNT(gnt[v]), .BUS_REQ(req[v]), .BUS_DESC_FETCH(descf[v]),
      .ACTIVE(act[v]), .ACTIVE_CH(ach[v]), .CH_PENDING(pend[v]), .ELEM_DONE(edone[v]),
      .CH_DONE(cdone[v]));
    dps_bus_arb_model arb (.clk(clk), .rst(rst), .bus_req(req[v]), .lat(lat),
      .bus_gnt(gnt[v]));
  end

  // 20 MHz core clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  // counts granted fetch cycles, elements, first finisher and pending holes;
  // a hung run is cut off here so it still reaches the verdict
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc >= LIMIT) begin
      miscompares++;
      stop_test();
    end else begin
      for (int v = 0; v < 2; v++) begin
        if (descf[v] && req[v] && gnt[v]) dcnt[v]++;
        if (edone[v]) ecnt[v]++;
        if (edone[v] && t_done[v] == 0) t_done[v] = cyc;
        for (int i = 0; i < 4; i++) if (cdone[v][i] && fdone[v] < 0) fdone[v] = i;
        if (watch != 0 && act[v] && ach[v] == 2'h0 && !pend[v][3]) viol[v]++;
      end
    end
  end

  task automatic clr();
    for (int v = 0; v < 2; v++) begin
      t_done[v] = 0;
      dcnt[v] = 0;
      ecnt[v] = 0;
      fdone[v] = -1;
      viol[v] = 0;
    end
  endtask : clr

  // one-cycle trigger; t0 is the cycle in which it is sampled
  task automatic fire(input logic [3:0] m);
    @(posedge clk);
    #1;
    trig = m;
    t0 = cyc;
    @(posedge clk);
    #1;
    trig = 4'h0;
  endtask : fire

  // two extra edges let the last done pulse reach the monitor
  task automatic wait_idle();
    int n;
    n = 0;
    while ((act !== 2'h0 || pend !== 8'h0) && n < 600) begin
      @(posedge clk);
      #1;
      n++;
    end
    repeat (2) @(posedge clk);
    #1;
    check("idle wait", n < 600, 32'h1);
  endtask : wait_idle

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_modes();
    for (int m = 0; m < 3; m++) begin
      mode = {4{2'(m)}};
      clr();
      fire(4'h1);
      wait_idle();
      for (int v = 0; v < 2; v++) begin
        check("trigger to element", t_done[v] - t0, 32'h10 + m);
        check("descriptor cycles", dcnt[v], 32'h5 + m);
      end
    end
    mode = 8'h0;
    $display("test modes done");
  endtask : t_modes

  // per-trigger 1d channel: only the memory variant skips setup on later triggers
  task automatic t_retain();
    per = 4'h1;
    mode = 8'h55;
    len = {4{16'h3}};
    for (int k = 0; k < 3; k++) begin
      clr();
      fire(4'h1);
      wait_idle();
      for (int v = 0; v < 2; v++) begin
        check("trigger to element", t_done[v] - t0, (v && k) ? 32'h8 : 32'h11);
        check("descriptor cycles", dcnt[v], (v && k) ? 32'h0 : 32'h6);
        check("transfer done", fdone[v], (k == 2) ? 32'h0 : 32'hffffffff);
      end
    end
    per = 4'h0;
    mode = 8'h0;
    len = {4{16'h1}};
    $display("test retain done");
  endtask : t_retain

  // per-trigger low channel 3 gives the engine to channel 1 between its two elements
  task automatic t_wait();
    per = 4'h8;
    len = {16'h2, 16'h1, 16'h1, 16'h1};
    clr();
    fire(4'h8);
    repeat (12) @(posedge clk);
    fire(4'h2);
    wait_idle();
    for (int v = 0; v < 2; v++) begin
      check("waiting yields", fdone[v], 32'h1);
      check("elements", ecnt[v], 32'h2);
    end
    clr();
    fire(4'h8);
    wait_idle();
    for (int v = 0; v < 2; v++) begin
      check("resumed finish", fdone[v], 32'h3);
      check("resume to element", t_done[v] - t0, v ? 32'h8 : 32'h10);
    end
    per = 4'h0;
    len = {4{16'h1}};
    $display("test wait done");
  endtask : t_wait

  // low channel 3 runs four elements; channel 0 arrives during its first one
  task automatic t_preempt(input logic p);
    pre = {p, 3'h0};
    len = {16'h4, 16'h1, 16'h1, 16'h1};
    watch = p;
    clr();
    fire(4'h8);
    repeat (12) @(posedge clk);
    fire(4'h1);
    wait_idle();
    watch = 0;
    for (int v = 0; v < 2; v++) begin
      check("first finished", fdone[v], p ? 32'h0 : 32'h3);
      check("descriptor cycles", dcnt[v], (p && v == 0) ? 32'hf : 32'ha);
      check("elements", ecnt[v], 32'h5);
      check("pending holes", viol[v], 32'h0);
    end
    pre = 4'h0;
    len = {4{16'h1}};
    $display("test preempt done");
  endtask : t_preempt

  task automatic t_master_priority_field();
    clr();
    fire(4'h6);
    wait_idle();
    check("priority pick", fdone[0], 32'h2);
    check("priority pick", fdone[1], 32'h2);
    master_priority_field = 8'hd4;
    clr();
    fire(4'h6);
    wait_idle();
    check("tie pick", fdone[0], 32'h1);
    check("tie pick", fdone[1], 32'h1);
    en = 4'hd;
    clr();
    fire(4'h2);
    repeat (20) @(posedge clk);
    #1;
    check("disabled elements", ecnt[0] + ecnt[1], 32'h0);
    check("disabled pending", pend, 8'h0);
    en = 4'hf;
    master_priority_field = 8'hd8;
    $display("test priority done");
  endtask : t_master_priority_field

  // other masters hold the bus for three cycles on each new request
  task automatic t_bus();
    lat = 4'h3;
    clr();
    fire(4'h1);
    wait_idle();
    for (int v = 0; v < 2; v++) begin
      check("stalled element", t_done[v] - t0, 32'h13);
      check("descriptor cycles", dcnt[v], 32'h5);
    end
    lat = 4'h0;
    $display("test bus done");
  endtask : t_bus

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    check("reset quiet", {act, req, pend}, 12'h0);
    t_modes();
    t_retain();
    t_wait();
    t_preempt(1'b1);
    t_preempt(1'b0);
    t_master_priority_field();
    t_bus();
    stop_test();
  end
endmodule : dps_sched_test
